// file: hw/flow_i2c_consts.vh
`ifndef FLOW_I2C_CONSTS_VH
`define FLOW_I2C_CONSTS_VH
// Target addressing
`define DEF_TARGET_ADDR 7'h08
`define GEN_CALL_ADDR 7'h00
`define SOFT_RESET_CODE 8'h06
// Command codes
`define CMD_START_WATER 16'h3608
`define CMD_START_IPA 16'h3615
`define CMD_STOP_DEFAULT 16'h3ff9
// Timing, in microseconds, and the clock rate in MHz
// Sized at 22 bits so the cycle products fit their counters exactly
`define REF_CLK_MHZ 22'h00007d
`define SAMPLE_PERIOD_US 22'h0001f4
`define FIRST_RESULT_US 22'h002ee0
`define STOP_RECOVER_US 22'h0001f4
`define SOFT_RESET_US 22'h0061a8
// Averaging: samples in the mean window, and the smoothing shift
`define MEAN_WINDOW 8'd200
`define SMOOTH_SHIFT 5'd6
// Checksum
`define CRC_POLY 8'h31
`define CRC_INIT 8'hff
// Flag word bit positions
`define FLAG_AIR 0
`define FLAG_HIGH 1
`define FLAG_SMOOTH 5
// Byte slot phases and frame layout
`define BIT_ACK 4'd8
`define BIT_WRAP 4'd9
`define FLAG_LO_IDX 4'd7
`define IDLE_BYTE 8'hff
// Register offsets
`define REG_STATUS 4'h0
`define REG_TARGET 4'h4
`endif

// file: hw/flow_sensor_i2c_command_readout.v
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "flow_i2c_consts.vh"
// Notes on behaviour
// - Answer as target at seven-bit address 8.
// - Reset restores default address, dropping changes.
// - Commands are 16 bits, high byte first.
// - Each returned word carries trailing checksum byte.
// - Master NACK ends transfer; release data line.
// - 0x3608 water, 0x3615 alcohol start measuring.
// - Each read header returns latest result set.
// - First result ready 12 ms after start.
// - NACK read header until first result exists.
// - Nine bytes: flow, temperature, flags, each checksummed.
// - Flag bits: 0 air, 1 high flow, 5 smoothing.
// - Other flag bits carry no meaning.
// - Stop halts measuring, heater off, idle.
// - After stop, busy up to 0.5 ms.
// - While measuring, only stop or soft reset accepted.
// - Flow refreshed every 0.5 ms, averaged since readout.
// - High flow flag holds until flags read.
// - Soft reset is one byte to general call.
// - Soft reset recovery 25 ms, deaf meanwhile; general call and its reset byte are still acked, restarting recovery.
module flow_sensor_i2c_command_readout #(
   parameter [15:0] CMD_STOP = `CMD_STOP_DEFAULT,
   parameter [21:0] SAMPLE_CYC = `REF_CLK_MHZ * `SAMPLE_PERIOD_US,
   parameter [21:0] FIRST_CYC = `REF_CLK_MHZ * `FIRST_RESULT_US,
   parameter [21:0] STOP_CYC = `REF_CLK_MHZ * `STOP_RECOVER_US,
   parameter [21:0] SRST_CYC = `REF_CLK_MHZ * `SOFT_RESET_US
) (
   // Clock and reset
   input wire ref_clk,
   input wire reset_n,
   // Bus pins, open drain
   input wire scl_in,
   output reg scl_out,
   output reg scl_oe,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   // Sensor front end, same clock
   input wire [15:0] flow_raw,
   input wire [15:0] temp_raw,
   input wire air_detect,
   input wire over_limit,
   output reg heater_on,
   output reg calib_ipa,
   // Register port
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [7:0] reg_rdata
);
   // Mode codes
   localparam M_IDLE = 2'd0;
   localparam M_MEAS = 2'd1;
   localparam M_STOP = 2'd2;
   localparam M_RESET = 2'd3;
   // Byte machine codes
   localparam B_IDLE = 2'd0;
   localparam B_ADDR = 2'd1;
   localparam B_WRITE = 2'd2;
   localparam B_READ = 2'd3;

   // Checksum over one data word, MSB first
   function [7:0] crc16;
      input [15:0] w;
      integer i;
      reg [7:0] c;
      begin
         c = `CRC_INIT;
         for (i = 15; i >= 0; i = i - 1) begin
            if (c[7] ^ w[i])
               c = {c[6:0], 1'b0} ^ `CRC_POLY;
            else
               c = {c[6:0], 1'b0};
         end
         crc16 = c;
      end
   endfunction

   // Averaging shift: rough log2 of sample count, then fixed smoothing
   function [4:0] shift_for;
      input [7:0] n;
      integer i;
      reg [8:0] m;
      begin
         m = {1'b0, n} + 9'h001;
         shift_for = 5'd0;
         for (i = 1; i < 9; i = i + 1) begin
            if (m[i])
               shift_for = i[4:0];
         end
         if (n >= `MEAN_WINDOW)
            shift_for = `SMOOTH_SHIFT;
      end
   endfunction

   // Synchronisers and previous sampled levels
   reg scl_s1, scl_s2, scl_d;
   reg sda_s1, sda_s2, sda_d;
   // Byte machine state
   reg [1:0] bstate;
   reg [3:0] bitcnt;
   reg [7:0] shreg;
   reg [7:0] txbyte;
   reg [71:0] frame;
   reg [3:0] byte_idx;
   reg acking;       // We own the current ack slot
   reg gen_call;     // Write addressed to general call
   reg wr_second;    // Next write byte is command low byte
   reg [7:0] cmd_hi;
   // Pulses from byte machine to measurement logic
   reg go_water, go_ipa, go_stop, soft_req, rd_flow, rd_flags;
   // Measurement state
   reg [1:0] mode;
   reg [21:0] mode_cnt;
   reg [21:0] sample_cnt;
   reg result_ready;
   reg [15:0] flow_avg;
   reg [15:0] temp_last;
   reg [7:0] avg_n;
   reg air_sticky, high_sticky;
   reg [6:0] target_addr;

   wire scl_rise = scl_s2 & ~scl_d;
   wire scl_fall = ~scl_s2 & scl_d;
   wire start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
   wire stop_cond = scl_s2 & scl_d & ~sda_d & sda_s2;
   wire smoothing = (avg_n >= `MEAN_WINDOW);
   wire tick = (mode == M_MEAS) && (sample_cnt == SAMPLE_CYC - 22'd1);
   wire [15:0] flags = ({15'h0000, air_sticky} << `FLAG_AIR)
                     | ({15'h0000, high_sticky} << `FLAG_HIGH)
                     | ({15'h0000, smoothing} << `FLAG_SMOOTH);
   wire [15:0] cmd = {cmd_hi, shreg};
   wire addr_hit = (shreg[7:1] == target_addr);
   wire deaf = (mode == M_RESET);
   wire [16:0] diff = {flow_raw[15], flow_raw} - {flow_avg[15], flow_avg};
   wire [16:0] step = $signed(diff) >>> shift_for(avg_n);

   // Two-stage sampling of the bus pins; only stage two is looked at
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_s1 <= scl_in;
         scl_s2 <= scl_s1;
         scl_d <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_d <= sda_s2;
      end
   end

   // Target byte machine: bits in on SCL rise, data line changed on fall
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         bstate <= B_IDLE;
         bitcnt <= 4'd0;
         shreg <= 8'h00;
         txbyte <= `IDLE_BYTE;
         frame <= 72'h0;
         byte_idx <= 4'd0;
         acking <= 1'b0;
         gen_call <= 1'b0;
         wr_second <= 1'b0;
         cmd_hi <= 8'h00;
         sda_oe <= 1'b0;
         sda_out <= 1'b0;
         scl_oe <= 1'b0;
         scl_out <= 1'b0;
         {go_water, go_ipa, go_stop, soft_req, rd_flow, rd_flags} <= 6'h00;
      end else begin
         {go_water, go_ipa, go_stop, soft_req, rd_flow, rd_flags} <= 6'h00;
         if (start_cond) begin
            // Start or repeated start: expect an address byte
            bstate <= B_ADDR;
            bitcnt <= 4'd0;
            acking <= 1'b0;
            sda_oe <= 1'b0;
         end else if (stop_cond || bstate == B_IDLE) begin
            // Off the bus; the data line stays released
            bstate <= B_IDLE;
            sda_oe <= 1'b0;
            acking <= 1'b0;
         end else if (scl_rise) begin
            if (bitcnt == `BIT_ACK) begin
               bitcnt <= `BIT_WRAP;
               // Master NACK on read data ends our part of the transfer
               if (bstate == B_READ && !acking && sda_s2)
                  bstate <= B_IDLE;
            end else begin
               bitcnt <= bitcnt + 4'd1;
               if (bstate != B_READ)
                  shreg <= {shreg[6:0], sda_s2};
            end
         end else if (scl_fall) begin
            case (bitcnt)
               `BIT_ACK: begin
                  acking <= 1'b0;
                  sda_oe <= 1'b0;
                  if (bstate == B_ADDR) begin
                     if (addr_hit && !deaf && !shreg[0]) begin
                        bstate <= B_WRITE;
                        gen_call <= 1'b0;
                        wr_second <= 1'b0;
                        acking <= 1'b1;
                        sda_oe <= 1'b1;
                     end else if (addr_hit && !deaf && mode == M_MEAS
                                  && result_ready) begin
                        // Freeze the latest set for this header
                        bstate <= B_READ;
                        frame <= {flow_avg, crc16(flow_avg),
                                  temp_last, crc16(temp_last),
                                  flags, crc16(flags)};
                        rd_flow <= 1'b1;
                        byte_idx <= 4'd0;
                        acking <= 1'b1;
                        sda_oe <= 1'b1;
                     end else if (shreg == {`GEN_CALL_ADDR, 1'b0}) begin
                        bstate <= B_WRITE;
                        gen_call <= 1'b1;
                        acking <= 1'b1;
                        sda_oe <= 1'b1;
                     end else begin
                        bstate <= B_IDLE;
                     end
                  end else if (bstate == B_WRITE) begin
                     if (gen_call) begin
                        // Only the reset byte is taken on general call
                        if (shreg == `SOFT_RESET_CODE) begin
                           soft_req <= 1'b1;
                           acking <= 1'b1;
                           sda_oe <= 1'b1;
                        end else
                           bstate <= B_IDLE;
                     end else if (!wr_second) begin
                        // High byte: taken unless recovering
                        if (mode == M_IDLE || mode == M_MEAS) begin
                           cmd_hi <= shreg;
                           wr_second <= 1'b1;
                           acking <= 1'b1;
                           sda_oe <= 1'b1;
                        end else
                           bstate <= B_IDLE;
                     end else begin
                        wr_second <= 1'b0;
                        if (mode == M_MEAS && cmd == CMD_STOP) begin
                           go_stop <= 1'b1;
                           acking <= 1'b1;
                           sda_oe <= 1'b1;
                        end else if (mode == M_IDLE
                                     && cmd == `CMD_START_WATER) begin
                           go_water <= 1'b1;
                           acking <= 1'b1;
                           sda_oe <= 1'b1;
                        end else if (mode == M_IDLE
                                     && cmd == `CMD_START_IPA) begin
                           go_ipa <= 1'b1;
                           acking <= 1'b1;
                           sda_oe <= 1'b1;
                        end else if (mode == M_IDLE && cmd == CMD_STOP) begin
                           acking <= 1'b1; // Harmless stop while idle
                           sda_oe <= 1'b1;
                        end else
                           bstate <= B_IDLE;
                     end
                  end
               end
               `BIT_WRAP: begin
                  // Ack slot over: start next byte
                  bitcnt <= 4'd0;
                  acking <= 1'b0;
                  if (bstate == B_READ) begin
                     txbyte <= frame[71:64];
                     sda_oe <= ~frame[71];
                     frame <= {frame[63:0], `IDLE_BYTE};
                     byte_idx <= byte_idx + 4'd1;
                     if (byte_idx == `FLAG_LO_IDX)
                        rd_flags <= 1'b1;
                  end else
                     sda_oe <= 1'b0;
               end
               default: begin
                  if (bstate == B_READ)
                     sda_oe <= ~txbyte[3'd7 - bitcnt[2:0]];
               end
            endcase
         end
      end
   end

   // Mode sequencing: start, stop recovery, soft reset recovery
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode <= M_IDLE;
         mode_cnt <= 22'd0;
         result_ready <= 1'b0;
         heater_on <= 1'b0;
         calib_ipa <= 1'b0;
      end else if (soft_req) begin
         mode <= M_RESET;
         mode_cnt <= 22'd0;
         result_ready <= 1'b0;
         heater_on <= 1'b0;
      end else begin
         case (mode)
            M_IDLE: begin
               if (go_water || go_ipa) begin
                  mode <= M_MEAS;
                  mode_cnt <= 22'd0;
                  result_ready <= 1'b0;
                  heater_on <= 1'b1;
                  calib_ipa <= go_ipa;
               end
            end
            M_MEAS: begin
               if (go_stop) begin
                  mode <= M_STOP;
                  mode_cnt <= 22'd0;
                  result_ready <= 1'b0;
                  heater_on <= 1'b0;
               end else if (mode_cnt == FIRST_CYC - 22'd1) begin
                  result_ready <= 1'b1;
               end else
                  mode_cnt <= mode_cnt + 22'd1;
            end
            M_STOP: begin
               if (mode_cnt == STOP_CYC - 22'd1)
                  mode <= M_IDLE;
               else
                  mode_cnt <= mode_cnt + 22'd1;
            end
            default: begin
               if (mode_cnt == SRST_CYC - 22'd1)
                  mode <= M_IDLE;
               else
                  mode_cnt <= mode_cnt + 22'd1;
            end
         endcase
      end
   end

   // Sample pacing, flow averaging and sticky event flags
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sample_cnt <= 22'd0;
         flow_avg <= 16'h0000;
         temp_last <= 16'h0000;
         avg_n <= 8'd0;
         air_sticky <= 1'b0;
         high_sticky <= 1'b0;
      end else begin
         if (mode != M_MEAS || tick)
            sample_cnt <= 22'd0;
         else
            sample_cnt <= sample_cnt + 22'd1;
         // A sample landing on a readout starts the new average
         if (tick && (rd_flow || avg_n == 8'd0)) begin
            flow_avg <= flow_raw;
            avg_n <= 8'd1;
         end else if (tick) begin
            flow_avg <= flow_avg + step[15:0];
            if (!smoothing)
               avg_n <= avg_n + 8'd1;
         end else if (rd_flow || mode != M_MEAS)
            avg_n <= 8'd0; // A restart must not reuse old samples
         if (tick)
            temp_last <= temp_raw;
         // Event set wins over readout clear
         air_sticky <= (air_sticky & ~rd_flags) | (tick & air_detect);
         high_sticky <= (high_sticky & ~rd_flags)
                      | (tick & over_limit);
      end
   end

   // Register port: own address and status, read data one cycle later
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         target_addr <= `DEF_TARGET_ADDR;
         reg_rdata <= 8'h00;
      end else begin
         if (soft_req)
            target_addr <= `DEF_TARGET_ADDR;
         else if (reg_write && reg_addr == `REG_TARGET)
            target_addr <= reg_wdata[6:0];
         if (reg_read && reg_addr == `REG_STATUS)
            reg_rdata <= {3'h0, smoothing, heater_on, result_ready, mode};
         else if (reg_read && reg_addr == `REG_TARGET)
            reg_rdata <= {1'b0, target_addr};
         else
            reg_rdata <= 8'h00;
      end
   end
endmodule

// file: testbench/flow_readout_asserts.sv
`timescale 1ns/1ps
// Port-level checks on the flow sensor bus target
module flow_readout_asserts (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Bus pins
   input wire logic scl_in,
   input wire logic scl_oe,
   input wire logic sda_oe,
   // Sensor control
   input wire logic heater_on,
   input wire logic calib_ipa,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   a_scl_free: assert property (!scl_oe)
      else $error("clock line was driven");
   // SDA may only move while SCL is low, or the master sees a false START or STOP
   a_sda_hold: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data drive changed while clock high");
   a_heater_rise: assert property ($rose(heater_on) |-> sda_oe)
      else $error("heater started outside an acknowledge");
   a_heater_fall: assert property ($fell(heater_on) |-> sda_oe)
      else $error("heater stopped outside an acknowledge");
   a_cal_stable: assert property (
      heater_on && $past(heater_on) |-> $stable(calib_ipa))
      else $error("calibration changed while measuring");
   a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
   a_status_map: assert property (
      $past(reg_read) && $past(reg_addr) == 4'h0 |->
      reg_rdata[7:5] == 3'b000 && reg_rdata[3] == $past(heater_on) &&
      reg_rdata[3] == (reg_rdata[1:0] == 2'b01))
      else $error("status word disagrees with heater");
   a_unmapped_zero: assert property (
      $past(reg_read) && $past(reg_addr) != 4'h0 &&
      $past(reg_addr) != 4'h4 |-> reg_rdata == 8'h00)
      else $error("unmapped address read nonzero");
endmodule

bind flow_sensor_i2c_command_readout flow_readout_asserts chk_u (
   .ref_clk(ref_clk),
   .reset_n(reset_n),
   .scl_in(scl_in),
   .scl_oe(scl_oe),
   .sda_oe(sda_oe),
   .heater_on(heater_on),
   .calib_ipa(calib_ipa),
   .reg_addr(reg_addr),
   .reg_read(reg_read),
   .reg_rdata(reg_rdata)
);

// file: testbench/i2c_master_model.sv
`timescale 1ns/1ps
// Bus master; SCL stands high between frames, 160 ns bit time
module i2c_master_model (
   // Bus lines, master side of the open drain
   output logic scl,
   output logic sda_m,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // SDA falls while SCL high
   task automatic start();
      sda_m <= 1'b1;
      #40 scl <= 1'b1;
      #40 sda_m <= 1'b0;
      #40 scl <= 1'b0;
   endtask
   // SDA rises while SCL high; closes any transfer
   task automatic stop();
      #40 sda_m <= 1'b0;
      #40 scl <= 1'b1;
      #40 sda_m <= 1'b1;
      #40;
   endtask
   // Data set mid-low, sampled mid-high
   task automatic bitx(input logic b, output logic r);
      #40 sda_m <= b;
      #40 scl <= 1'b1;
      #40 r = sda;
      #40 scl <= 1'b0;
   endtask
   // Byte MSB first, then the ninth bit; a high releases SDA
   task automatic xfer(input logic [7:0] d, input logic a,
                       output logic [7:0] q, output logic r);
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], q[i]);
      end
      bitx(a, r);
   endtask
endmodule

// file: testbench/flow_sensor_i2c_command_readout_tb_top.sv
`timescale 1ns/1ps
`include "flow_i2c_consts.vh"
module flow_sensor_i2c_command_readout_tb_top;
   // Clock, reset and pins
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic scl_oe, sda_oe, scl_m, sda_m, heater_on, calib_ipa, scl_o, sda_o;
   logic [15:0] flow_raw = 16'h1234;
   logic [15:0] temp_raw = 16'h0c80;
   logic air_detect = 1'b0;
   logic over_limit = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [7:0] reg_rdata, d;
   logic [2:0] k;
   logic [71:0] f;
   int n_errors = 0;
   int cmp_count = 0;
   // Pulled-up wires
   wire scl_w = scl_m & ~scl_oe;
   wire sda_w = sda_m & ~sda_oe;

   always #4 ref_clk = ~ref_clk;

   // Shortened counts keep the run brief
   flow_sensor_i2c_command_readout #(.SAMPLE_CYC(22'd50),
      .FIRST_CYC(22'd400), .STOP_CYC(22'd800), .SRST_CYC(22'd600)) dut_u (
      .ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl_w),
      .scl_out(scl_o), .scl_oe(scl_oe), .sda_in(sda_w),
      .sda_out(sda_o), .sda_oe(sda_oe),
      .flow_raw(flow_raw), .temp_raw(temp_raw), .air_detect(air_detect),
      .over_limit(over_limit), .heater_on(heater_on),
      .calib_ipa(calib_ipa), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));

   i2c_master_model mst_u (.scl(scl_m), .sda_m(sda_m), .sda(sda_w));

   task automatic chk(input string nm, input logic [79:0] s,
                      input logic [79:0] e);
      cmp_count++;
      if (s !== e) begin
         n_errors++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
   endtask
   // Up to three bytes; stops at the first refusal, returns acks
   task automatic send(input logic [23:0] b, input int n,
                       output logic [2:0] ak);
      logic [7:0] q;
      logic r;
      ak = 3'b000;
      mst_u.start();
      for (int i = 0; i < n; i++) begin
         mst_u.xfer(b[23 - 8 * i -: 8], 1'b1, q, r);
         ak[2 - i] = !r;
         if (r) break;
      end
      mst_u.stop();
   endtask
   // Read header then n bytes, last one refused by the master
   task automatic rdf(input int n, output logic [2:0] ak,
                      output logic [71:0] fr);
      logic [7:0] q;
      logic r, x;
      fr = '0;
      repeat (60) @(posedge ref_clk);
      mst_u.start();
      mst_u.xfer(8'h11, 1'b1, q, r);
      ak = {!r, 2'b00};
      for (int i = 0; i < n && !r; i++) begin
         mst_u.xfer(8'hff, i == n - 1, q, x);
         fr[71 - 8 * i -: 8] = q;
      end
      mst_u.stop();
   endtask
   function automatic logic [7:0] crc8(input logic [15:0] w);
      logic [7:0] c;
      c = 8'hff;
      for (int i = 15; i >= 0; i--) begin
         c = (c[7] ^ w[i]) ? {c[6:0], 1'b0} ^ 8'h31 : {c[6:0], 1'b0};
      end
      return c;
   endfunction
   // Inputs are held constant, so the mean equals the sample
   function automatic logic [71:0] frame(input logic [15:0] fl);
      return {flow_raw, crc8(flow_raw), temp_raw, crc8(temp_raw),
              fl, crc8(fl)};
   endfunction
   task automatic tally_and_finish();
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd(4'h4, d);
      chk("target", d, 8'h08);
      chk("low drive", {scl_o, sda_o, scl_oe}, 3'b000);
      chk("crc ref", crc8(16'hbeef), 8'h92);
      wr(4'h8, 8'h5a);
      rd(4'h8, d);
      chk("unmapped", d, 8'h00);
      rdf(9, k, f);
      chk("idle read", k, 3'b000);
      send({8'h10, 16'h1234}, 3, k);
      chk("bad code", {k, heater_on}, 4'b1100);
      send({8'h10, 16'h3608}, 3, k);
      chk("water", {k, heater_on, calib_ipa}, 5'b11110);
      rd(4'h0, d);
      chk("warming", d, 8'h09);
      rdf(9, k, f);
      chk("not ready", k, 3'b000);
      send({8'h10, 16'h3615}, 3, k);
      chk("busy code", {k, calib_ipa}, 4'b1100);
      @(posedge ref_clk);
      air_detect <= 1'b1;
      over_limit <= 1'b1;
      repeat (400) @(posedge ref_clk);
      air_detect <= 1'b0;
      over_limit <= 1'b0;
      rdf(9, k, f);
      chk("frame 1", {k, f}, {3'b100, frame(16'h0003)});
      rdf(9, k, f);
      chk("frame 2", f, frame(16'h0000));
      rdf(3, k, f);
      chk("flow only", f[71:48], frame(16'h0000) >> 48);
      chk("released", sda_oe, 1'b0);
      @(posedge ref_clk);
      over_limit <= 1'b1;
      repeat (100) @(posedge ref_clk);
      over_limit <= 1'b0;
      repeat (10300) @(posedge ref_clk);
      rdf(9, k, f);
      chk("smoothed", f, frame(16'h0022));
      send({8'h10, `CMD_STOP_DEFAULT}, 3, k);
      chk("stop", {k, heater_on}, 4'b1110);
      send({8'h10, 16'h3615}, 3, k);
      chk("recovering", k, 3'b100);
      rd(4'h0, d);
      chk("stopping", d, 8'h02);
      repeat (900) @(posedge ref_clk);
      send({8'h10, 16'h3615}, 3, k);
      chk("alcohol", {k, heater_on, calib_ipa}, 5'b11111);
      wr(4'h4, 8'h22);
      rd(4'h4, d);
      chk("moved", d, 8'h22);
      send({8'h00, 8'h06, 8'h00}, 2, k);
      chk("soft reset", {k, heater_on}, 4'b1100);
      send({8'h10, 16'h0000}, 1, k);
      chk("deaf", k, 3'b000);
      rd(4'h0, d);
      chk("reset status", d, 8'h03);
      repeat (700) @(posedge ref_clk);
      rd(4'h4, d);
      chk("home", d, 8'h08);
      send({8'h10, 16'h0000}, 1, k);
      chk("back", k, 3'b100);
      send({8'h10, `CMD_STOP_DEFAULT}, 3, k);
      chk("idle stop", {k, heater_on}, 4'b1110);
      // Hard reset in mid-run must also drop a moved address
      wr(4'h4, 8'h33);
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd(4'h4, d);
      chk("hard reset", d, 8'h08);
      tally_and_finish();
   end

   // Hang guard, several times the expected run
   initial begin
      #600000;
      n_errors++;
      tally_and_finish();
   end
endmodule
